// ===== cps_pkg.sv
package cps_pkg;

   // Register indexes inside sector 0; byte address on APB is four times these
   localparam logic [3:0] IDX_PORT0   = 4'h0;
   localparam logic [3:0] IDX_PTR0    = 4'h1;
   localparam logic [3:0] IDX_PORT1   = 4'h2;
   localparam logic [3:0] IDX_P1LO    = 4'h3;
   localparam logic [3:0] IDX_P1SEC   = 4'h4;
   localparam logic [3:0] IDX_ACC     = 4'h5;
   localparam logic [3:0] IDX_PCLO    = 4'h6;
   localparam logic [3:0] IDX_TBLO    = 4'h7;
   localparam logic [3:0] IDX_TBHL    = 4'h8;
   localparam logic [3:0] IDX_TBHI    = 4'h9;
   localparam logic [3:0] IDX_FLAGS   = 4'ha;
   localparam logic [3:0] IDX_GAP     = 4'hb;
   localparam logic [3:0] IDX_PORT2   = 4'hc;
   localparam logic [3:0] IDX_P2LO    = 4'hd;
   localparam logic [3:0] IDX_P2SEC   = 4'he;
   localparam logic [3:0] IDX_FOREIGN = 4'hf;

   // Flag bit positions in core_condition_flags
   localparam int FLG_C  = 0;
   localparam int FLG_AC = 1;
   localparam int FLG_Z  = 2;
   localparam int FLG_OV = 3;
   localparam int FLG_PD = 4;
   localparam int FLG_TO = 5;
   localparam int FLG_CZ = 6;
   localparam int FLG_SC = 7;

   // Bits an instruction write may change
   localparam logic [7:0] FLAGS_WR_MASK = 8'hcf;
   localparam logic [7:0] FLAGS_RESET   = 8'h00;
   localparam logic [7:0] PTR_RESET     = 8'h00;
   localparam logic [7:0] ZERO_BYTE     = 8'h00;

   typedef enum logic [3:0] {
      CPS_ADD, CPS_ADC, CPS_SUB, CPS_SBC, CPS_AND, CPS_OR, CPS_XOR,
      CPS_RLC, CPS_RRC, CPS_MOV
   } cps_alu_e;

   typedef enum logic {
      TBL_IDLE, TBL_WAIT
   } cps_tbl_e;

endpackage : cps_pkg

// ===== cps_flag_unit.sv
`timescale 1ns/100ps
`default_nettype none
module cps_flag_unit
   import cps_pkg::*;
(
   // Operation
   input  wire cps_alu_e   op,
   input  wire logic [7:0] a,
   input  wire logic [7:0] b,
   input  wire logic       c_in,
   // Result and flags
   output logic [7:0]      result,
   output logic            c_out,
   output logic            ac_out,
   output logic            z_out,
   output logic            ov_out,
   output logic            sc_out,
   output logic            upd_arith,
   output logic            upd_c,
   output logic            upd_z
);

   // Subtraction is a + ~b + carry, so carry out means no borrow
   wire       is_sub  = (op == CPS_SUB) || (op == CPS_SBC);
   wire       is_ar   = is_sub || (op == CPS_ADD) || (op == CPS_ADC);
   wire [7:0] b_eff   = is_sub ? ~b : b;
   wire       cin_eff = (op == CPS_SUB) ? 1'b1 :
                        ((op == CPS_ADC) || (op == CPS_SBC)) ? c_in : 1'b0;
   wire [8:0] sum9    = {1'b0, a} + {1'b0, b_eff} + {8'h00, cin_eff};
   wire [4:0] sum5    = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin_eff};
   wire [7:0] sum7    = {1'b0, a[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, cin_eff};

   always_comb
   begin
      result = sum9[7:0];
      c_out  = sum9[8];
      case (op)
         CPS_AND: result = a & b;
         CPS_OR:  result = a | b;
         CPS_XOR: result = a ^ b;
         CPS_MOV: result = b;
         CPS_RLC:
         begin
            result = {a[6:0], c_in};
            c_out  = a[7];
         end
         CPS_RRC:
         begin
            result = {c_in, a[7:1]};
            c_out  = a[0];
         end
         default: result = sum9[7:0];
      endcase
   end

   assign ac_out    = sum5[4];
   assign ov_out    = sum7[7] ^ sum9[8];
   assign sc_out    = ov_out ^ result[7];
   assign z_out     = (result == 8'h00);
   assign upd_arith = is_ar;
   assign upd_c     = is_ar || (op == CPS_RLC) || (op == CPS_RRC);
   assign upd_z     = !((op == CPS_RLC) || (op == CPS_RRC));

endmodule : cps_flag_unit
`default_nettype wire

// ===== cps_core_regs.sv
`timescale 1ns/100ps
`default_nettype none
module cps_core_regs
   import cps_pkg::*;
#(
   parameter int AW     = 11,
   parameter int PC_W   = 13,
   parameter int APB_AW = 8
)
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset,
   // APB register slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [APB_AW-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   // Instruction data access
   input  wire logic              ins_valid,
   input  wire logic              ins_write,
   input  wire logic [AW-1:0]     ins_addr,
   // ALU operation
   input  wire logic              alu_go,
   input  wire cps_alu_e          alu_op,
   input  wire logic [7:0]        alu_operand,
   // Data memory
   output logic                   dm_en,
   output logic                   dm_we,
   output logic      [AW-1:0]     dm_addr,
   output logic      [7:0]        dm_wdata,
   input  wire logic [7:0]        dm_rdata,
   // Program counter
   input  wire logic [PC_W-1:0]   pc_now,
   output logic                   pc_load,
   output logic      [PC_W-1:0]   pc_load_addr,
   output logic                   pc_dummy,
   // Table read
   input  wire logic              tbl_go,
   input  wire logic [AW-1:0]     tbl_dest,
   output logic                   prog_req,
   output logic      [PC_W-1:0]   prog_addr,
   input  wire logic              prog_ack,
   input  wire logic [15:0]       prog_data,
   // System events
   input  wire logic              wdt_timeout,
   input  wire logic              watchdog_kick_instr,
   input  wire logic              halt_instr,
   // State view
   output logic      [7:0]        acc,
   output logic      [7:0]        core_condition_flags
);

   logic [7:0]      sector0_pointer;
   logic [7:0]      ptr1_low_byte;
   logic [7:0]      ptr1_sector_byte;
   logic [7:0]      ptr2_low_byte;
   logic [7:0]      ptr2_sector_byte;
   logic [7:0]      table_ptr_low;
   logic [7:0]      table_ptr_high;
   logic [7:0]      table_high_latch;
   logic [AW-1:0]   tbl_dest_eff;
   logic            dm_pend;
   cps_tbl_e        tbl_state;
   logic [7:0]      next_acc;
   logic [7:0]      next_flags;
   logic [7:0]      sfr_view [16];

   function automatic logic cps_in_sfr(input logic [AW-1:0] a);
      return (a[AW-1:4] == '0);
   endfunction : cps_in_sfr

   // Registers of this block; the last slot belongs to another block
   function automatic logic cps_is_own(input logic [AW-1:0] a);
      return cps_in_sfr(a) && (a[3:0] != IDX_GAP) && (a[3:0] != IDX_FOREIGN);
   endfunction : cps_is_own

   function automatic logic cps_is_port(input logic [3:0] idx);
      return (idx == IDX_PORT0) || (idx == IDX_PORT1) || (idx == IDX_PORT2);
   endfunction : cps_is_port

   // Upper address bits select the sector, the low byte the location
   function automatic logic [AW-1:0] cps_resolve(input logic [AW-1:0] a);
      logic [AW-1:0] r;
      r = a;
      if (cps_in_sfr(a))
      begin
         case (a[3:0])
            IDX_PORT0: r = {{(AW-8){1'b0}}, sector0_pointer};
            IDX_PORT1: r = {ptr1_sector_byte[AW-9:0], ptr1_low_byte};
            IDX_PORT2: r = {ptr2_sector_byte[AW-9:0], ptr2_low_byte};
            default:   r = a;
         endcase
      end
      return r;
   endfunction : cps_resolve

   // Ports have no storage and read as zero
   always_comb
   begin
      for (int i = 0; i < 16; i++)
         sfr_view[i] = ZERO_BYTE;
      sfr_view[IDX_PTR0]  = sector0_pointer;
      sfr_view[IDX_P1LO]  = ptr1_low_byte;
      sfr_view[IDX_P1SEC] = ptr1_sector_byte;
      sfr_view[IDX_ACC]   = acc;
      sfr_view[IDX_PCLO]  = pc_now[7:0];
      sfr_view[IDX_TBLO]  = table_ptr_low;
      sfr_view[IDX_TBHL]  = table_high_latch;
      sfr_view[IDX_TBHI]  = table_ptr_high;
      sfr_view[IDX_FLAGS] = core_condition_flags;
      sfr_view[IDX_P2LO]  = ptr2_low_byte;
      sfr_view[IDX_P2SEC] = ptr2_sector_byte;
   end

   // APB decode; reads answer one cycle into the access phase
   wire [3:0]    apb_idx    = paddr[5:2];
   wire          apb_hit    = (paddr[APB_AW-1:6] == '0) && (paddr[1:0] == 2'b00);
   wire          apb_access = psel && penable;
   wire          apb_we     = apb_access && pready && pwrite && apb_hit;

   // Instruction address after pointer redirection
   // A process, not an assign: the function also reads the pointers
   logic [AW-1:0] ins_eff;
   always_comb
   begin
      ins_eff = cps_resolve(ins_addr);
   end
   wire          ins_own    = cps_is_own(ins_eff);
   wire          tbl_done   = (tbl_state == TBL_WAIT) && prog_ack;

   // One write path for instruction stores and table low bytes
   wire          wr_go      = tbl_done || (ins_valid && ins_write);
   wire [AW-1:0] wr_addr    = tbl_done ? tbl_dest_eff : ins_eff;
   wire [7:0]    wr_data    = tbl_done ? prog_data[7:0] : acc;
   wire          wr_own     = wr_go && cps_is_own(wr_addr);
   wire          rd_own     = ins_valid && !ins_write && ins_own;
   wire          rd_mem     = ins_valid && !ins_write && !ins_own;

   // Instruction side wins a same-cycle collision with APB
   wire          sel_we     = wr_own || apb_we;
   wire [3:0]    sel_idx    = wr_own ? wr_addr[3:0] : apb_idx;
   wire [7:0]    sel_data   = wr_own ? wr_data : pwdata[7:0];
   wire          sel_ok     = sel_we && !cps_is_port(sel_idx);

   wire [7:0]    fu_result;
   wire          fu_c;
   wire          fu_ac;
   wire          fu_z;
   wire          fu_ov;
   wire          fu_sc;
   wire          fu_upd_arith;
   wire          fu_upd_c;
   wire          fu_upd_z;

   cps_flag_unit i_cps_flag_unit
   (
      .op        (alu_op),
      .a         (acc),
      .b         (alu_operand),
      .c_in      (core_condition_flags[FLG_C]),
      .result    (fu_result),
      .c_out     (fu_c),
      .ac_out    (fu_ac),
      .z_out     (fu_z),
      .ov_out    (fu_ov),
      .sc_out    (fu_sc),
      .upd_arith (fu_upd_arith),
      .upd_c     (fu_upd_c),
      .upd_z     (fu_upd_z)
   );

   // Accumulator sources
   always_comb
   begin
      next_acc = acc;
      if (dm_pend)
         next_acc = dm_rdata;
      else if (alu_go)
         next_acc = fu_result;
      else if (rd_own)
         next_acc = sfr_view[ins_eff[3:0]];
      else if (sel_ok && sel_idx == IDX_ACC)
         next_acc = sel_data;
   end

   // Flags land on the same edge as the result
   always_comb
   begin
      next_flags = core_condition_flags;
      if (sel_ok && sel_idx == IDX_FLAGS)
         next_flags = (core_condition_flags & ~FLAGS_WR_MASK)
                    | (sel_data & FLAGS_WR_MASK);
      if (alu_go)
      begin
         if (fu_upd_c)
            next_flags[FLG_C] = fu_c;
         if (fu_upd_z)
            next_flags[FLG_Z] = fu_z;
         if (fu_upd_arith)
         begin
            next_flags[FLG_AC] = fu_ac;
            next_flags[FLG_OV] = fu_ov;
            next_flags[FLG_SC] = fu_sc;
         end
         if (alu_op == CPS_SUB)
            next_flags[FLG_CZ] = fu_z;
         else if (alu_op == CPS_SBC)
            next_flags[FLG_CZ] = core_condition_flags[FLG_CZ] & fu_z;
      end
      // Hardware set wins over a same-cycle clear
      if (wdt_timeout)
         next_flags[FLG_TO] = 1'b1;
      else if (watchdog_kick_instr || halt_instr)
         next_flags[FLG_TO] = 1'b0;
      if (halt_instr)
         next_flags[FLG_PD] = 1'b1;
      else if (watchdog_kick_instr)
         next_flags[FLG_PD] = 1'b0;
   end

   // No path to any stack exists here, so software must save the flags
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         acc                  <= ZERO_BYTE;
         core_condition_flags <= FLAGS_RESET;
      end
      else
      begin
         acc                  <= next_acc;
         core_condition_flags <= next_flags;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         sector0_pointer  <= PTR_RESET;
         ptr1_low_byte    <= PTR_RESET;
         ptr1_sector_byte <= PTR_RESET;
         ptr2_low_byte    <= PTR_RESET;
         ptr2_sector_byte <= PTR_RESET;
         table_ptr_low    <= PTR_RESET;
         table_ptr_high   <= PTR_RESET;
      end
      else if (sel_ok)
      begin
         case (sel_idx)
            IDX_PTR0:  sector0_pointer  <= sel_data;
            IDX_P1LO:  ptr1_low_byte    <= sel_data;
            IDX_P1SEC: ptr1_sector_byte <= sel_data;
            IDX_P2LO:  ptr2_low_byte    <= sel_data;
            IDX_P2SEC: ptr2_sector_byte <= sel_data;
            IDX_TBLO:  table_ptr_low    <= sel_data;
            IDX_TBHI:  table_ptr_high   <= sel_data;
            default:   sector0_pointer  <= sector0_pointer;
         endcase
      end
   end

   // Eight-bit write keeps the current page
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pc_load      <= 1'b0;
         pc_load_addr <= '0;
         pc_dummy     <= 1'b0;
      end
      else
      begin
         pc_load  <= sel_ok && (sel_idx == IDX_PCLO);
         pc_dummy <= pc_load;
         if (sel_ok && sel_idx == IDX_PCLO)
            pc_load_addr <= {pc_now[PC_W-1:8], sel_data};
      end
   end

   // Table read: one fetch outstanding at a time
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         tbl_state        <= TBL_IDLE;
         prog_req         <= 1'b0;
         prog_addr        <= '0;
         tbl_dest_eff     <= '0;
         table_high_latch <= ZERO_BYTE;
      end
      else
      begin
         prog_req <= 1'b0;
         case (tbl_state)
            TBL_IDLE:
               if (tbl_go)
               begin
                  prog_req     <= 1'b1;
                  prog_addr    <= PC_W'({table_ptr_high, table_ptr_low});
                  tbl_dest_eff <= cps_resolve(tbl_dest);
                  tbl_state    <= TBL_WAIT;
               end
            TBL_WAIT:
               if (prog_ack)
               begin
                  table_high_latch <= prog_data[15:8];
                  tbl_state        <= TBL_IDLE;
               end
            default: tbl_state <= TBL_IDLE;
         endcase
      end
   end

   // Data memory port, registered
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         dm_en    <= 1'b0;
         dm_we    <= 1'b0;
         dm_addr  <= '0;
         dm_wdata <= ZERO_BYTE;
         dm_pend  <= 1'b0;
      end
      else
      begin
         dm_en   <= rd_mem || (wr_go && !wr_own);
         dm_we   <= wr_go && !wr_own;
         dm_pend <= rd_mem && !wr_go;
         if (wr_go && !wr_own)
         begin
            dm_addr  <= wr_addr;
            dm_wdata <= wr_data;
         end
         else if (rd_mem)
            dm_addr <= ins_eff;
      end
   end

   // APB answer; unmapped addresses read zero and ignore writes
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pready <= 1'b0;
         prdata <= '0;
      end
      else
      begin
         pready <= apb_access && !pready;
         if (apb_access && !pready)
            prdata <= {24'h000000, apb_hit ? sfr_view[apb_idx] : ZERO_BYTE};
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_pcl_write;
      sel_ok && (sel_idx == IDX_PCLO);
   endsequence
   sequence s_pcl_jump;
      ##1 (pc_load && !pc_dummy) ##1 (pc_dummy && !pc_load);
   endsequence

   AST_PCL_DUMMY: assert property (s_pcl_write |-> s_pcl_jump)
      else $error("Low counter write without single dummy cycle");
   AST_PCL_PAGE: assert property (s_pcl_write |=>
         pc_load_addr == {$past(pc_now[PC_W-1:8]), $past(sel_data)})
      else $error("Jump left the current page");
   AST_TO_SET: assert property (wdt_timeout |=> core_condition_flags[FLG_TO])
      else $error("Watchdog flag not set on timeout");
   AST_TO_CLR: assert property ((watchdog_kick_instr || halt_instr) && !wdt_timeout
         |=> !core_condition_flags[FLG_TO])
      else $error("Watchdog flag not cleared");
   AST_PD_FLAG: assert property (halt_instr |=> core_condition_flags[FLG_PD])
      else $error("Sleep flag not set by halt");
   AST_PD_CLR: assert property (watchdog_kick_instr && !halt_instr
         |=> !core_condition_flags[FLG_PD])
      else $error("Sleep flag not cleared by kick");
   AST_FLAG_WR_KEEP: assert property (sel_ok && sel_idx == IDX_FLAGS && !wdt_timeout
         && !watchdog_kick_instr && !halt_instr
         |=> $stable(core_condition_flags[FLG_TO:FLG_PD]))
      else $error("Flag write changed watchdog or sleep bit");
   AST_CZ_SUB: assert property (alu_go && alu_op == CPS_SUB
         |=> core_condition_flags[FLG_CZ] == core_condition_flags[FLG_Z])
      else $error("Chained flag differs from zero after subtract");
   AST_CZ_SBC: assert property (alu_go && alu_op == CPS_SBC |=> core_condition_flags[FLG_CZ]
         == ($past(core_condition_flags[FLG_CZ]) & core_condition_flags[FLG_Z]))
      else $error("Chained flag wrong after borrow subtract");
   AST_SC_XOR: assert property (alu_go && !dm_pend && fu_upd_arith |=> core_condition_flags[FLG_SC]
         == (core_condition_flags[FLG_OV] ^ acc[7]))
      else $error("Signed compare flag mismatch");
   AST_PORT0_SECTOR: assert property (rd_mem && ins_addr == AW'(IDX_PORT0) && !wr_go
         |=> dm_en && dm_addr[AW-1:8] == '0)
      else $error("Port zero left sector zero");
   AST_APB_PORT_ZERO: assert property (apb_access && pready && !pwrite && apb_hit
         && cps_is_port(apb_idx) |-> prdata == '0)
      else $error("Port read returned nonzero");
   AST_TBL_LATCH: assert property (tbl_done |=> table_high_latch == $past(prog_data[15:8]))
      else $error("Table high byte not latched");

endmodule : cps_core_regs
`default_nettype wire

// ===== core_pointer_and_status_regs_test.sv
`timescale 1ns/100ps
`default_nettype none
module core_pointer_and_status_regs_test
   import cps_pkg::*;
;
   logic        clk = 1'b0;
   logic        reset, psel, penable, pwrite, ins_valid, ins_write, alu_go, tbl_go;
   logic        prog_ack, wdt_timeout, watchdog_kick_instr, halt_instr;
   logic        dm_en, dm_we, pready, pc_load, pc_dummy, prog_req;
   logic [7:0]  paddr, alu_operand, dm_rdata, dm_wdata, acc, core_condition_flags, q;
   logic [31:0] pwdata, prdata;
   logic [10:0] ins_addr, tbl_dest, dm_addr;
   logic [12:0] pc_now, pc_load_addr, prog_addr;
   logic [15:0] prog_data;
   cps_alu_e    alu_op;
   int          num_errors, total_checks, cycles;

   cps_core_regs i_cps_core_regs (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .ins_valid, .ins_write, .ins_addr, .alu_go, .alu_op, .alu_operand,
      .dm_en, .dm_we, .dm_addr, .dm_wdata, .dm_rdata, .pc_now, .pc_load, .pc_load_addr,
      .pc_dummy, .tbl_go, .tbl_dest, .prog_req, .prog_addr, .prog_ack, .prog_data,
      .wdt_timeout, .watchdog_kick_instr, .halt_instr, .acc, .core_condition_flags);

   always #2 clk = ~clk;

   task give_verdict;
      if (num_errors == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict

   // Hung handshakes end here instead of running forever
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         num_errors++;
         give_verdict();
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [7:0] ra(input logic [3:0] i);
      return {2'b00, i, 2'b00};
   endfunction : ra

   task apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      q = prdata[7:0];
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rd(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk(q, e);
   endtask : rd

   task ins(input logic wr, input logic [10:0] a, input logic [10:0] e);
      @(posedge clk);
      ins_valid <= 1'b1;
      ins_write <= wr;
      ins_addr <= a;
      @(posedge clk);
      ins_valid <= 1'b0;
      #1;
      chk({dm_en, dm_we, dm_addr}, {1'b1, wr, e});
      @(posedge clk);
      #1;
   endtask : ins

   task alu(input cps_alu_e op, input logic [7:0] b, input logic [7:0] ea, input logic [7:0] ef);
      @(posedge clk);
      alu_go <= 1'b1;
      alu_op <= op;
      alu_operand <= b;
      @(posedge clk);
      alu_go <= 1'b0;
      #1;
      chk({acc, core_condition_flags}, {ea, ef});
   endtask : alu

   task ev(input logic [2:0] e, input logic [7:0] ef);
      @(posedge clk);
      {wdt_timeout, watchdog_kick_instr, halt_instr} <= e;
      @(posedge clk);
      {wdt_timeout, watchdog_kick_instr, halt_instr} <= 3'b000;
      #1;
      chk(core_condition_flags, ef);
   endtask : ev

   task t_regs;
      rd(ra(IDX_P1SEC), 8'h00);
      rd(ra(IDX_P2SEC), 8'h00);
      chk(core_condition_flags, 8'h00);
      apb(1'b1, ra(IDX_P1LO), 8'h40);
      apb(1'b1, ra(IDX_P1SEC), 8'h01);
      apb(1'b1, ra(IDX_PTR0), 8'h23);
      apb(1'b1, ra(IDX_PORT1), 8'h99);
      rd(ra(IDX_P1LO), 8'h40);
      rd(ra(IDX_P1SEC), 8'h01);
      rd(ra(IDX_PORT1), 8'h00);
      rd(8'h2c, 8'h00);
   endtask : t_regs

   task t_indirect;
      ins(1'b0, 11'h002, 11'h140);
      chk(acc, 8'h5a);
      ins(1'b0, 11'h000, 11'h023);
      ins(1'b1, 11'h1f0, 11'h1f0);
      @(posedge clk);
      {ins_valid, ins_write, ins_addr} <= {2'b11, 11'h003};
      @(posedge clk);
      ins_valid <= 1'b0;
      #1;
      chk(dm_en, 1'b0);
      rd(ra(IDX_P1LO), 8'h5a);
   endtask : t_indirect

   task t_flags;
      apb(1'b1, ra(IDX_FLAGS), 8'hff);
      rd(ra(IDX_FLAGS), 8'hcf);
      apb(1'b1, ra(IDX_FLAGS), 8'h00);
      apb(1'b1, ra(IDX_ACC), 8'h7f);
      alu(CPS_ADD, 8'h01, 8'h80, 8'h0a);
      alu(CPS_SUB, 8'h80, 8'h00, 8'h47);
      alu(CPS_SBC, 8'h00, 8'h00, 8'h47);
      alu(CPS_SBC, 8'h01, 8'hff, 8'h80);
      alu(CPS_AND, 8'h00, 8'h00, 8'h84);
      apb(1'b1, ra(IDX_ACC), 8'h80);
      alu(CPS_RLC, 8'h00, 8'h00, 8'h85);
      alu(CPS_RRC, 8'h00, 8'h80, 8'h84);
      alu(CPS_ADC, 8'h7f, 8'hff, 8'h80);
      alu(CPS_XOR, 8'hff, 8'h00, 8'h84);
      alu(CPS_OR, 8'h3c, 8'h3c, 8'h80);
      alu(CPS_MOV, 8'h00, 8'h00, 8'h84);
      ev(3'b001, 8'h94);
      apb(1'b1, ra(IDX_FLAGS), 8'h00);
      rd(ra(IDX_FLAGS), 8'h10);
      ev(3'b100, 8'h30);
      ev(3'b001, 8'h10);
      ev(3'b100, 8'h30);
      ev(3'b010, 8'h00);
      ev(3'b110, 8'h20);
   endtask : t_flags

   task t_pc_table;
      rd(ra(IDX_PCLO), 8'h34);
      apb(1'b1, ra(IDX_PCLO), 8'h56);
      repeat (4)
      begin
         #1;
         if (pc_load === 1'b1)
            break;
         @(posedge clk);
      end
      chk({pc_load, pc_load_addr}, {1'b1, 13'h1256});
      @(posedge clk);
      #1;
      chk({pc_dummy, pc_load}, 2'b10);
      apb(1'b1, ra(IDX_TBLO), 8'h34);
      apb(1'b1, ra(IDX_TBHI), 8'h12);
      @(posedge clk);
      tbl_go <= 1'b1;
      tbl_dest <= 11'h080;
      @(posedge clk);
      tbl_go <= 1'b0;
      repeat (4)
      begin
         #1;
         if (prog_req === 1'b1)
            break;
         @(posedge clk);
      end
      chk({prog_req, prog_addr}, {1'b1, 13'h1234});
      // Slow program memory answer
      repeat (3) @(posedge clk);
      prog_ack <= 1'b1;
      prog_data <= 16'habcd;
      @(posedge clk);
      prog_ack <= 1'b0;
      #1;
      chk({dm_we, dm_addr, dm_wdata}, {1'b1, 11'h080, 8'hcd});
      rd(ra(IDX_TBHL), 8'hab);
   endtask : t_pc_table

   initial
   begin
      {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
      {ins_valid, ins_write, ins_addr, alu_go, alu_operand} = 22'h0;
      {tbl_go, tbl_dest, prog_ack, prog_data} = 29'h0;
      {wdt_timeout, watchdog_kick_instr, halt_instr} = 3'b000;
      alu_op = CPS_ADD;
      pc_now = 13'h1234;
      dm_rdata = 8'h5a;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      t_indirect();
      t_flags();
      t_pc_table();
      give_verdict();
   end
endmodule : core_pointer_and_status_regs_test
`default_nettype wire
